// File: hw/dmpfc_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmpfc_top
	import dmpfc_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic ARST_N,
	// wishbone slave
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [11:2] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	// fetched display words
	input wire logic WORD_VALID,
	output logic WORD_READY,
	input wire logic [31:0] WORD_DATA,
	input wire logic WORD_OVL,
	// pin input
	input wire logic GENERAL_PIN_ZERO,
	// pixels toward the panel
	output logic PIX_VALID,
	input wire logic PIX_READY,
	output logic [17:0] PIX_DATA,
	output logic PIX_OVL,
	// window state
	output logic OVERLAY_ENABLE,
	output logic [3:0] ROT_ANGLE
);
	// ==========================================================
	// registers and bus
	logic [7:0] mode_ff, fx_ff, lut_idx_ff;
	logic cfg_passive_ff;
	logic wvalid_ff, wovl_ff;
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic [17:0] lut_ff [DMPFC_LUT_N];
	logic req, wr_en;
	logic blank, dith_dis, hw_inv, sw_inv, passive;
	logic [2:0] depth;
	logic [3:0] fifo_cnt;

	assign req = CYC_I && STB_I && !ack_ff;
	assign wr_en = req && WE_I && SEL_I[0];
	assign blank = mode_ff[DMPFC_BLANK_BIT];
	assign dith_dis = mode_ff[DMPFC_DITH_DIS_BIT];
	assign hw_inv = mode_ff[DMPFC_HW_INV_BIT];
	assign sw_inv = mode_ff[DMPFC_SW_INV_BIT];
	assign depth = mode_ff[2:0];
	assign passive = cfg_passive_ff;
	assign ACK_O = ack_ff;
	assign DAT_O = rdat_ff;

	// one wait-free cycle: ack comes the edge after the request is seen
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= req;
		end
	end

	// control registers; unmapped writes fall through harmlessly
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_ff <= DMPFC_MODE_RST;
			fx_ff <= DMPFC_FX_RST;
			lut_idx_ff <= 8'h00;
			cfg_passive_ff <= 1'b0;
		end else if (wr_en) begin
			if (ADR_I == DMPFC_MODE_IDX) begin
				mode_ff <= DAT_I[7:0] & DMPFC_MODE_WMASK;
			end else if (ADR_I == DMPFC_FX_IDX) begin
				fx_ff <= DAT_I[7:0] & DMPFC_FX_WMASK;
			end else if (ADR_I == DMPFC_LUTI_IDX) begin
				lut_idx_ff <= DAT_I[7:0];
			end else if (ADR_I == DMPFC_LUTD_IDX) begin
				lut_idx_ff <= lut_idx_ff + 8'h01; // stream a whole table in one go
			end else if (ADR_I == DMPFC_CFG_IDX) begin
				cfg_passive_ff <= DAT_I[DMPFC_PASSIVE_BIT];
			end
		end
	end

	// table entries; contents have no reset, software loads them first
	always_ff @(posedge CLK) begin
		if (wr_en && ADR_I == DMPFC_LUTD_IDX) begin
			lut_ff[lut_idx_ff] <= DAT_I[17:0];
		end
	end

	// read data, zero for unmapped addresses and unused bits
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdat_ff <= 32'h0000_0000;
		end else if (req) begin
			if (ADR_I == DMPFC_MODE_IDX) begin
				rdat_ff <= {24'h00_0000, mode_ff};
			end else if (ADR_I == DMPFC_FX_IDX) begin
				rdat_ff <= {24'h00_0000, fx_ff};
			end else if (ADR_I == DMPFC_LUTI_IDX) begin
				rdat_ff <= {24'h00_0000, lut_idx_ff};
			end else if (ADR_I == DMPFC_LUTD_IDX) begin
				rdat_ff <= {14'h0000, lut_ff[lut_idx_ff]};
			end else if (ADR_I == DMPFC_CFG_IDX) begin
				rdat_ff <= {31'h0000_0000, cfg_passive_ff};
			end else if (ADR_I == DMPFC_STAT_IDX) begin
				rdat_ff <= {26'h000_0000, wvalid_ff, PIX_VALID, fifo_cnt};
			end else begin
				rdat_ff <= 32'h0000_0000;
			end
		end
	end

	// ==========================================================
	// window state outputs
	assign OVERLAY_ENABLE = fx_ff[DMPFC_OVL_EN_BIT];
	// rotation decoded one-hot: bit0=0, bit1=90, bit2=180, bit3=270 degrees
	assign ROT_ANGLE = 4'h1 << fx_ff[1:0];

	// ==========================================================
	// pin synchroniser: three stages, a change counts once stages 2 and 3 agree
	logic [2:0] pin_sync_ff;
	logic pin_level_ff;
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_sync_ff <= 3'h0;
			pin_level_ff <= 1'b0;
		end else begin
			pin_sync_ff <= {pin_sync_ff[1:0], GENERAL_PIN_ZERO};
			if (pin_sync_ff[1] == pin_sync_ff[2]) begin
				pin_level_ff <= pin_sync_ff[2];
			end
		end
	end

	// ==========================================================
	// swap before buffering so pixel order inside the word follows the swap
	logic [31:0] swapped;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [32:0] fifo_out;
	dmpfc_swap u_swap (
		.word_swap(fx_ff[DMPFC_WSWAP_BIT]),
		.byte_swap(fx_ff[DMPFC_BSWAP_BIT]),
		.din(WORD_DATA),
		.dout(swapped)
	);
	dmpfc_fifo #(
		.W(DMPFC_WORD_W + 1),
		.D(DMPFC_FIFO_D)
	) u_fifo (
		.clk(CLK),
		.arst_n(ARST_N),
		.in_valid(WORD_VALID),
		.in_ready(fifo_in_ready),
		.in_data({WORD_OVL, swapped}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out),
		.count(fifo_cnt)
	);
	assign WORD_READY = fifo_in_ready;

	// ==========================================================
	// pixel extraction
	logic [31:0] word_ff;
	logic [4:0] idx_ff, last_idx, sh;
	logic depth_ok, advance, last, out_valid_ff, out_ovl_ff;
	logic [17:0] out_data_ff;
	logic [31:0] raw;

	// depth decode: last pixel index in a word and bit offset of the current one
	always_comb begin
		depth_ok = 1'b1;
		last_idx = 5'd31;
		sh = idx_ff;
		case (depth)
			DMPFC_BPP1: begin
				last_idx = 5'd31;
				sh = idx_ff;
			end
			DMPFC_BPP2: begin
				last_idx = 5'd15;
				sh = {idx_ff[3:0], 1'b0};
			end
			DMPFC_BPP4: begin
				last_idx = 5'd7;
				sh = {idx_ff[2:0], 2'b00};
			end
			DMPFC_BPP8: begin
				last_idx = 5'd3;
				sh = {idx_ff[1:0], 3'b000};
			end
			DMPFC_BPP16: begin
				last_idx = 5'd1;
				sh = {idx_ff[0], 4'h0};
			end
			default: begin
				depth_ok = 1'b0; // reserved codes stall the pipe
			end
		endcase
	end

	assign last = idx_ff >= last_idx;
	// a blanked pipe takes nothing from the buffer and emits nothing
	assign advance = wvalid_ff && depth_ok && !blank && (!out_valid_ff || PIX_READY);
	assign fifo_pop = fifo_out_valid && !blank && (!wvalid_ff || (advance && last));
	assign raw = word_ff >> sh;

	// current word holder; first pixel sits in the low bits
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wvalid_ff <= 1'b0;
			wovl_ff <= 1'b0;
			word_ff <= 32'h0000_0000;
			idx_ff <= 5'h00;
		end else if (fifo_pop) begin
			wvalid_ff <= 1'b1;
			wovl_ff <= fifo_out[32];
			word_ff <= fifo_out[31:0];
			idx_ff <= 5'h00;
		end else if (advance) begin
			if (last) begin
				wvalid_ff <= 1'b0;
			end
			idx_ff <= idx_ff + 5'h01;
		end
	end

	// ==========================================================
	// colour: table or bypass, then inversion, then dithering
	logic [7:0] pix_code;
	logic [17:0] color_pre, color_inv, color_out;
	logic inv_on;
	logic [1:0] pos_ff;

	// only the bits of the current depth select a table entry
	always_comb begin
		case (depth)
			DMPFC_BPP1: pix_code = {7'h00, raw[0]};
			DMPFC_BPP2: pix_code = {6'h00, raw[1:0]};
			DMPFC_BPP4: pix_code = {4'h0, raw[3:0]};
			default: pix_code = raw[7:0];
		endcase
	end

	// 16 bpp widens 5-6-5 to 6-6-6 by repeating the top bit
	assign color_pre = (depth == DMPFC_BPP16) ?
		{raw[15:11], raw[15], raw[10:5], raw[4:0], raw[4]} : lut_ff[pix_code];
	assign inv_on = hw_inv ? pin_level_ff : sw_inv;
	assign color_inv = color_pre ^ {DMPFC_COLOR_W{inv_on}};

	// ordered dither: threshold from pixel position added to dropped bits
	function automatic logic [5:0] dith6(input logic [5:0] c, input logic [1:0] thr);
		logic [6:0] s;
		s = {1'b0, c} + {5'h00, thr};
		dith6 = (s[6] ? 6'h3F : s[5:0]) & 6'h3C;
	endfunction

	// passive panels keep 4 bits per colour; dithering makes up 64 levels
	always_comb begin
		color_out = color_inv;
		if (passive) begin
			if (dith_dis) begin
				color_out = color_inv & 18'h3CF3C;
			end else begin
				color_out = {dith6(color_inv[17:12], pos_ff), dith6(color_inv[11:6], ~pos_ff),
					dith6(color_inv[5:0], {pos_ff[0], pos_ff[1]})};
			end
		end
	end

	// ==========================================================
	// output stage; overlay pixels share depth and rotation of the main window
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= 18'h00000;
			out_ovl_ff <= 1'b0;
			pos_ff <= 2'h0;
		end else if (blank) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= 18'h00000;
			out_ovl_ff <= 1'b0;
		end else if (advance) begin
			out_valid_ff <= 1'b1;
			out_data_ff <= color_out;
			out_ovl_ff <= wovl_ff && OVERLAY_ENABLE;
			pos_ff <= pos_ff + 2'h1;
		end else if (PIX_READY) begin
			out_valid_ff <= 1'b0;
			out_ovl_ff <= 1'b0; // a stale overlay flag must not outlive its pixel
		end
	end
	assign PIX_VALID = out_valid_ff;
	assign PIX_DATA = out_data_ff;
	assign PIX_OVL = out_ovl_ff;

	// ==========================================================
	// checks
	a_blank_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		blank |=> (PIX_DATA == 18'h00000) && !PIX_VALID)
		else $error("blank did not clear pixel outputs");
	a_blank_no_pop: assert property (@(posedge CLK) disable iff (!ARST_N)
		blank |-> !fifo_pop && !advance)
		else $error("blanked pipe still moves data");
	a_pin_inverts: assert property (@(posedge CLK) disable iff (!ARST_N)
		(hw_inv && GENERAL_PIN_ZERO) [*5] |-> inv_on)
		else $error("pin high did not invert video");
	a_pin_ignored: assert property (@(posedge CLK) disable iff (!ARST_N)
		!hw_inv && $changed(pin_level_ff) |-> inv_on == sw_inv)
		else $error("pin affects video with hardware invert off");
	a_lut_bypass: assert property (@(posedge CLK) disable iff (!ARST_N)
		advance && depth == DMPFC_BPP16 && !passive |=>
		PIX_DATA[17:13] == ($past(raw[15:11]) ^ {5{$past(inv_on)}}))
		else $error("16 bpp did not bypass the table");
	a_dither_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		advance && passive && dith_dis |=> (PIX_DATA & 18'h030C3) == 18'h00000)
		else $error("undithered passive output keeps low bits");
	a_depth_bound: assert property (@(posedge CLK) disable iff (!ARST_N)
		wvalid_ff && depth == DMPFC_BPP16 |-> idx_ff <= 5'd1)
		else $error("pixel index beyond word at 16 bpp");
	a_depth_reserved: assert property (@(posedge CLK) disable iff (!ARST_N)
		depth > 3'h4 |-> !advance)
		else $error("reserved depth produced pixels");
	a_rot_decode: assert property (@(posedge CLK) disable iff (!ARST_N)
		fx_ff[1:0] == 2'h2 |-> ROT_ANGLE == 4'h4)
		else $error("rotation decode wrong");
	a_ovl_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		PIX_OVL |-> $past(OVERLAY_ENABLE))
		else $error("overlay pixel without overlay enable");
	a_ack_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
		CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
		else $error("bus answer not a single pulse");
	c_pix16: cover property (@(posedge CLK) disable iff (!ARST_N)
		advance && depth == DMPFC_BPP16);
	c_blank: cover property (@(posedge CLK) disable iff (!ARST_N)
		$rose(blank) && PIX_VALID);
	c_hw_inv: cover property (@(posedge CLK) disable iff (!ARST_N)
		advance && hw_inv && inv_on);
	c_fifo_full: cover property (@(posedge CLK) disable iff (!ARST_N)
		!fifo_in_ready && WORD_VALID);
endmodule // dmpfc_top
`default_nettype wire

// File: inc/dmpfc_pkg.sv
// How it works
// - blank bit stops the pipe and forces every pixel data output low
// - passive panels are dithered unless the dither-disable bit is set
// - with hardware invert enabled, pin zero high inverts video, low passes it
// - without hardware invert, the software invert bit alone selects inversion
// - inversion acts on colour after the look-up table, not on raw data
// - depth code 0..4 selects 1,2,4,8,16 bpp; codes 5..7 are reserved
// - one depth setting serves the main and the overlay window alike
// - 1 to 8 bpp go through the 18-bit table; 16 bpp bypass it
// - word swap exchanges the 16-bit halves of each fetched word
// - byte swap exchanges bytes 0/1 and 2/3 of each fetched word
// - word and byte swap together reverse the byte order of the word
// - overlay enable marks overlay pixels, sharing depth and rotation
// - rotation code 0..3 selects 0, 90, 180 or 270 degrees
package dmpfc_pkg;
	// ==========================================================
	// register map (index = word address, byte address = 4 * index)
	localparam logic [9:0] DMPFC_MODE_IDX = 10'h070;
	localparam logic [9:0] DMPFC_FX_IDX = 10'h071;
	localparam logic [9:0] DMPFC_LUTI_IDX = 10'h080;
	localparam logic [9:0] DMPFC_LUTD_IDX = 10'h081;
	localparam logic [9:0] DMPFC_CFG_IDX = 10'h082;
	localparam logic [9:0] DMPFC_STAT_IDX = 10'h083;
	localparam logic [7:0] DMPFC_MODE_RST = 8'h00;
	localparam logic [7:0] DMPFC_FX_RST = 8'h00;
	localparam logic [7:0] DMPFC_MODE_WMASK = 8'hF7;
	localparam logic [7:0] DMPFC_FX_WMASK = 8'hD3;
	// ==========================================================
	// field positions
	localparam int DMPFC_BLANK_BIT = 7;
	localparam int DMPFC_DITH_DIS_BIT = 6;
	localparam int DMPFC_HW_INV_BIT = 5;
	localparam int DMPFC_SW_INV_BIT = 4;
	localparam int DMPFC_WSWAP_BIT = 7;
	localparam int DMPFC_BSWAP_BIT = 6;
	localparam int DMPFC_OVL_EN_BIT = 4;
	localparam int DMPFC_PASSIVE_BIT = 0;
	// ==========================================================
	// sizes
	localparam int DMPFC_WORD_W = 32;
	localparam int DMPFC_FIFO_D = 8;
	localparam int DMPFC_COLOR_W = 18;
	localparam int DMPFC_LUT_N = 256;
	typedef enum logic [2:0] {
		DMPFC_BPP1 = 3'h0,
		DMPFC_BPP2 = 3'h1,
		DMPFC_BPP4 = 3'h2,
		DMPFC_BPP8 = 3'h3,
		DMPFC_BPP16 = 3'h4
	} dmpfc_bpp_e;
endpackage

// File: hw/dmpfc_swap.sv
`timescale 1ns/1ps
`default_nettype none
module dmpfc_swap
	import dmpfc_pkg::*;
(
	// control
	input wire logic word_swap,
	input wire logic byte_swap,
	// data
	input wire logic [31:0] din,
	output logic [31:0] dout
);
	logic [31:0] w;
	// halves first, then bytes inside halves: both together reverse the word
	assign w = word_swap ? {din[15:0], din[31:16]} : din;
	assign dout = byte_swap ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
	// ==========================================================
	// checks
	always_comb begin
		a_swap_both: assert (!(word_swap && byte_swap) ||
			dout == {din[7:0], din[15:8], din[23:16], din[31:24]})
			else $error("full swap does not reverse bytes");
		a_swap_word: assert (!(word_swap && !byte_swap) ||
			dout == {din[15:0], din[31:16]})
			else $error("word swap wrong");
		a_swap_byte: assert (!(!word_swap && byte_swap) ||
			dout == {din[23:16], din[31:24], din[7:0], din[15:8]})
			else $error("byte swap wrong");
	end
endmodule // dmpfc_swap
`default_nettype wire

// File: hw/dmpfc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dmpfc_fifo #(
	parameter int W = 33,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// level
	output logic [$clog2(D):0] count
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	localparam logic [AW-1:0] LAST = (AW)'(D - 1);
	logic [W-1:0] mem_ff [D];
	logic [AW-1:0] wr_ff, rd_ff;
	logic [AW:0] cnt_ff;
	logic push, pop;
	assign in_ready = cnt_ff != FULL;
	assign out_valid = cnt_ff != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ff];
	assign count = cnt_ff;
	// storage has no reset: only written slots are ever read
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end
	// pointers and level
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
			end
			if (push && !pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (pop && !push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule // dmpfc_fifo
`default_nettype wire

// File: tb/dmpfc_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// panel model: a sink for the pixel stream that records what it takes
module dmpfc_panel_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// pixel stream
	input wire logic pix_valid,
	output logic pix_ready,
	input wire logic [17:0] pix_data,
	input wire logic pix_ovl,
	// pacing
	input wire logic stall,
	input wire logic slow
);
	logic [18:0] got[$];
	logic ph_ff;
	// ready moves only after an edge; slow mode takes every other cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ph_ff <= 1'b0;
			pix_ready <= 1'b0;
		end else begin
			ph_ff <= ~ph_ff;
			pix_ready <= !stall && !(slow && ph_ff);
		end
	end
	// overlay flag kept above the colour so one compare covers both
	always @(posedge clk) begin
		if (arst_n && pix_valid && pix_ready) begin
			got.push_back({pix_ovl, pix_data});
		end
	end
endmodule // dmpfc_panel_model
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import dmpfc_pkg::*;
;
	typedef struct {logic [7:0] fx; logic [7:0] md; logic pin; logic inv; logic [31:0] sw;} dmpfc_row_s;
	localparam logic [31:0] W0 = 32'h11223344;
	logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic wvalid = 1'b0, wovl = 1'b0, pin = 1'b0, stall = 1'b0, slow = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h0, wdata = 32'h0, dat_o, q;
	logic ack, wready, pvalid, pready, povl, oven;
	logic [17:0] pdata;
	logic [3:0] rot;
	int n_errors = 0, checks_done = 0, acc, k, d;
	// swapped word written out by hand for the word 11223344
	dmpfc_row_s rows[5] = '{
		'{8'h00, 8'h04, 1'b0, 1'b0, 32'h11223344},
		'{8'h80, 8'h14, 1'b0, 1'b1, 32'h33441122},
		'{8'h40, 8'h04, 1'b1, 1'b0, 32'h22114433},
		'{8'hC0, 8'h24, 1'b1, 1'b1, 32'h44332211},
		'{8'h90, 8'h34, 1'b0, 1'b0, 32'h33441122}};
	always #50 clk = ~clk;
	dmpfc_top i_dmpfc_top (.CLK(clk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
		.WORD_VALID(wvalid), .WORD_READY(wready), .WORD_DATA(wdata), .WORD_OVL(wovl),
		.GENERAL_PIN_ZERO(pin), .PIX_VALID(pvalid), .PIX_READY(pready), .PIX_DATA(pdata),
		.PIX_OVL(povl), .OVERLAY_ENABLE(oven), .ROT_ANGLE(rot));
	dmpfc_panel_model i_dmpfc_panel_model (.clk(clk), .arst_n(arst_n), .pix_valid(pvalid),
		.pix_ready(pready), .pix_data(pdata), .pix_ovl(povl), .stall(stall), .slow(slow));
	// ==========================================================
	// tasks
	task automatic rst();
		arst_n <= 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
	endtask
	// classic cycle: request held until ack is seen at an edge
	task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] v);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= v;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// offer one word and hold it until the buffer takes it
	task automatic push(input logic [31:0] w);
		wvalid <= 1'b1;
		wdata <= w;
		do begin
			@(posedge clk);
		end while (wready !== 1'b1);
		wvalid <= 1'b0;
	endtask
	// bounded wait, then a settle so extra pixels would be counted too
	task automatic pix(input int n);
		for (int i = 0; i < 2000 && i_dmpfc_panel_model.got.size() < n; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		cmp(32'(i_dmpfc_panel_model.got.size()), 32'(n));
	endtask
	function automatic logic [17:0] c16(input logic [15:0] p, input logic inv);
		logic [17:0] c;
		c = {p[15:11], p[15], p[10:5], p[4:0], p[4]};
		return inv ? ~c : c;
	endfunction
	task automatic wrap_up();
		if (n_errors == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// watchdog sized well above the few hundred cycles the run needs
	initial begin
		#3000000;
		n_errors++;
		wrap_up();
	end
	// ==========================================================
	// main sequence
	initial begin
		rst();
		cmp(32'(rot), 32'h1);
		bus(DMPFC_MODE_IDX, 1'b0, 32'h0);
		cmp(q, 32'h0);
		bus(DMPFC_MODE_IDX, 1'b1, 32'hFF);
		bus(DMPFC_MODE_IDX, 1'b0, 32'h0);
		cmp(q, 32'hF7);
		bus(DMPFC_FX_IDX, 1'b1, 32'hFF);
		bus(DMPFC_FX_IDX, 1'b0, 32'h0);
		cmp(q, 32'hD3);
		bus(10'h3FF, 1'b0, 32'h0);
		cmp(q, 32'h0);
		for (k = 0; k < 4; k++) begin
			bus(DMPFC_FX_IDX, 1'b1, 32'(8'h10 | k));
			cmp(32'({oven, rot}), 32'h10 | (32'h1 << k));
		end
		// pin only ever an input here, on a plain panel
		wovl <= 1'b1;
		foreach (rows[i]) begin
			pin <= rows[i].pin;
			bus(DMPFC_FX_IDX, 1'b1, 32'(rows[i].fx));
			bus(DMPFC_MODE_IDX, 1'b1, 32'(rows[i].md));
			i_dmpfc_panel_model.got.delete();
			push(W0);
			pix(2);
			for (k = 0; k < 2; k++) begin
				cmp(32'(i_dmpfc_panel_model.got[k]), 32'({rows[i].fx[4], c16(rows[i].sw[16*k+:16], rows[i].inv)}));
			end
		end
		// table translation, then inversion on the translated colour
		bus(DMPFC_FX_IDX, 1'b1, 32'h0);
		bus(DMPFC_LUTI_IDX, 1'b1, 32'h0);
		bus(DMPFC_LUTD_IDX, 1'b1, 32'h3F03F);
		bus(DMPFC_LUTI_IDX, 1'b1, 32'h44);
		bus(DMPFC_LUTD_IDX, 1'b1, 32'h00FC1);
		bus(DMPFC_MODE_IDX, 1'b1, 32'h13);
		i_dmpfc_panel_model.got.delete();
		push(32'h44);
		pix(4);
		cmp(32'(i_dmpfc_panel_model.got[0]), 32'h3F03E);
		cmp(32'(i_dmpfc_panel_model.got[1]), 32'h00FC0);
		for (d = 0; d < 3; d++) begin
			bus(DMPFC_MODE_IDX, 1'b1, 32'(d));
			i_dmpfc_panel_model.got.delete();
			push(32'h0);
			pix(32 >> d);
			cmp(32'(i_dmpfc_panel_model.got[(32 >> d) - 1]), 32'h3F03F);
		end
		bus(DMPFC_CFG_IDX, 1'b1, 32'h1);
		bus(DMPFC_MODE_IDX, 1'b1, 32'h44);
		i_dmpfc_panel_model.got.delete();
		push(32'h0000FFFF);
		pix(2);
		cmp(32'(i_dmpfc_panel_model.got[0]), 32'h3CF3C);
		// dithered passive output: four neighbouring pixels spread the low bits
		bus(DMPFC_LUTI_IDX, 1'b1, 32'h0);
		bus(DMPFC_LUTD_IDX, 1'b1, 32'h02082);
		bus(DMPFC_MODE_IDX, 1'b1, 32'h0);
		i_dmpfc_panel_model.got.delete();
		push(32'h0);
		pix(32);
		acc = 0;
		for (k = 0; k < 4; k++) begin
			acc += 32'(i_dmpfc_panel_model.got[k][17:12]);
			acc += 32'(i_dmpfc_panel_model.got[k][11:6]);
			acc += 32'(i_dmpfc_panel_model.got[k][5:0]);
		end
		cmp(32'(acc), 32'h18);
		bus(DMPFC_CFG_IDX, 1'b1, 32'h0);
		// reserved depth stalls; fill to refusal while the panel stalls too
		stall <= 1'b1;
		bus(DMPFC_MODE_IDX, 1'b1, 32'h5);
		i_dmpfc_panel_model.got.delete();
		push(32'h0);
		repeat (20) @(posedge clk);
		cmp(32'(i_dmpfc_panel_model.got.size()), 32'h0);
		acc = 1;
		wvalid <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (wready === 1'b1) acc++;
			else break;
		end
		wvalid <= 1'b0;
		bus(DMPFC_STAT_IDX, 1'b0, 32'h0);
		cmp(32'(q[3:0]), 32'h8);
		stall <= 1'b0;
		slow <= 1'b1;
		bus(DMPFC_MODE_IDX, 1'b1, 32'h4);
		pix(2 * acc);
		// blank while a pixel waits at the output
		slow <= 1'b0;
		stall <= 1'b1;
		i_dmpfc_panel_model.got.delete();
		push(W0);
		repeat (6) @(posedge clk);
		cmp(32'(pvalid), 32'h1);
		bus(DMPFC_MODE_IDX, 1'b1, 32'h84);
		repeat (2) @(posedge clk);
		cmp(32'({pvalid, pdata}), 32'h0);
		stall <= 1'b0;
		repeat (12) @(posedge clk);
		cmp(32'(i_dmpfc_panel_model.got.size()), 32'h0);
		rst();
		cmp(32'({pvalid, pdata, povl, oven, rot}), 32'h1);
		bus(DMPFC_MODE_IDX, 1'b0, 32'h0);
		cmp(q, 32'h0);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
